// ===== hdl/mcd_decoder.sv
`timescale 1ns/1ps
// What this block does
// - Interrupts active only after enable 255.
// - Opcodes 40 to 45 are calculations.
// - Decode 46, 48 and 49.
// - Decode 80, 50 and 51.
// - Decode indexed variable opcodes 55 to 57.
// - Rotate right: velocity mode, param 2.
// - Rotate left: velocity mode, negated param 2.
// - Soft stop: velocity mode, param 0 zero.
// - Rotate right opcode 01h, value MSB first.
// - Rotate left opcode 02h, nine-byte frame.
// - Motion commands reply status 100.
// - No nesting; irq_active held until return.
// - Each interrupt number owns a vector.
module mcd_decoder
    import mcd_pkg::*;
(
    input  wire logic          clk,          // System clock, 25 MHz.
    input  wire logic          rst_b,        // Async reset, active low.
    input  wire logic          byte_valid,   // Serial byte strobe.
    input  wire logic [7:0]    byte_data,    // Serial byte.
    input  wire logic [7:0]    module_addr,  // Configured module address.
    input  wire logic          irq_request,  // Pending source request.
    input  wire logic [7:0]    irq_number,   // Requesting source number.
    output mcd_axis_wr_type    axis_wr,      // Motion controller write.
    output mcd_reply_type      reply,        // Reply to host.
    output mcd_class_type      cmd_class,    // Class of last command.
    output logic               irq_global,   // Global interrupt enable.
    output logic               irq_enter,    // Handler entry pulse.
    output logic               irq_active,   // Handler running.
    output logic [7:0]         irq_cfg_type, // Last bank 3 config type.
    output logic [31:0]        irq_cfg_value // Last bank 3 config value.
);
    mcd_frame_type frame;
    logic          frame_done;
    logic          frame_sum_ok;

    // Byte assembly and checksum test.
    mcd_frame_rx u_rx (
        .clk          (clk),
        .rst_b        (rst_b),
        .byte_valid   (byte_valid),
        .byte_data    (byte_data),
        .frame        (frame),
        .frame_done   (frame_done),
        .frame_sum_ok (frame_sum_ok)
    );

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_VMODE = 3'b010,
        ST_PARAM = 3'b100
    } mcd_state_type;

    mcd_state_type   st_ff, nxt_st;
    mcd_axis_wr_type axis_ff, nxt_axis;
    mcd_reply_type   reply_ff, nxt_reply;
    mcd_class_type   class_ff, nxt_class;
    logic [7:0]      pend_param_ff, nxt_pend_param;
    logic [31:0]     pend_value_ff, nxt_pend_value;
    logic            glob_ff, nxt_glob;
    logic            enter_ff, nxt_enter;
    logic            active_ff, nxt_active;
    logic [255:0]    src_en_ff, nxt_src_en;
    logic [255:0]    vec_ok_ff, nxt_vec_ok;
    logic [7:0]      cfg_type_ff, nxt_cfg_type;
    logic [31:0]     cfg_val_ff, nxt_cfg_val;
    logic            accept;
    logic [7:0]      op;

    assign accept = frame_done && frame_sum_ok
                    && (frame.addr == module_addr);
    assign op = frame.opcode;

    // Decode, motion sequencing, reply and interrupt control.
    always_comb begin
        nxt_st         = st_ff;
        nxt_axis       = '0;
        nxt_reply      = '0;
        nxt_class      = class_ff;
        nxt_pend_param = pend_param_ff;
        nxt_pend_value = pend_value_ff;
        nxt_glob       = glob_ff;
        nxt_enter      = 1'b0;
        nxt_active     = active_ff;
        nxt_src_en     = src_en_ff;
        nxt_vec_ok     = vec_ok_ff;
        nxt_cfg_type   = cfg_type_ff;
        nxt_cfg_val    = cfg_val_ff;
        case (st_ff)
            ST_IDLE: begin
                if (frame_done && frame_sum_ok
                    && frame.addr == module_addr) begin
                    nxt_reply.valid  = 1'b1;
                    nxt_reply.opcode = op;
                    nxt_reply.status = STATUS_OK;
                    nxt_class        = CLS_NONE;
                    if (op == OP_ROTATE_RIGHT) begin
                        nxt_class      = CLS_MOTION;
                        nxt_pend_param = AXIS_TARGET_VEL;
                        nxt_pend_value = frame.value;
                        nxt_st         = ST_VMODE;
                    end else if (op == OP_ROTATE_LEFT) begin
                        nxt_class      = CLS_MOTION;
                        nxt_pend_param = AXIS_TARGET_VEL;
                        nxt_pend_value = 32'h0 - frame.value;
                        nxt_st         = ST_VMODE;
                    end else if (op == OP_SOFT_STOP) begin
                        nxt_class      = CLS_MOTION;
                        nxt_pend_param = AXIS_TARGET_SPEED;
                        nxt_pend_value = 32'h0;
                        nxt_st         = ST_VMODE;
                    end else if (op >= OP_CALC_FIRST
                                 && op <= OP_CALC_LAST) begin
                        nxt_class = CLS_CALC;
                    end else if (op == OP_MOVE_ACCU_POS) begin
                        nxt_class = CLS_MOTION;
                    end else if (op == OP_RESTART
                                 || op == OP_DEC_BRANCH
                                 || op == OP_COND_CALL) begin
                        nxt_class = CLS_BRANCH;
                    end else if (op == OP_ROTATE_L_ACCU
                                 || op == OP_ROTATE_R_ACCU) begin
                        nxt_class = CLS_MOTION;
                    end else if (op >= OP_SET_IDX_VAR
                                 && op <= OP_ACCU_IDX_VAR) begin
                        nxt_class = CLS_INDEXED;
                    end else if (op == OP_SET_GLOBAL) begin
                        nxt_class = CLS_PARAM;
                        if (frame.bank == INT_CFG_BANK) begin
                            nxt_cfg_type = frame.ctype;
                            nxt_cfg_val  = frame.value;
                        end
                    end else if (op == OP_DEFINE_VECTOR) begin
                        nxt_class = CLS_INTR;
                        nxt_vec_ok[frame.ctype] = 1'b1;
                    end else if (op == OP_INT_ENABLE) begin
                        nxt_class = CLS_INTR;
                        if (frame.ctype == INT_GLOBAL_NUM) begin
                            nxt_glob = 1'b1;
                        end else begin
                            nxt_src_en[frame.ctype] = 1'b1;
                        end
                    end else if (op == OP_INT_DISABLE) begin
                        nxt_class = CLS_INTR;
                        if (frame.ctype == INT_GLOBAL_NUM) begin
                            nxt_glob = 1'b0;
                        end else begin
                            nxt_src_en[frame.ctype] = 1'b0;
                        end
                    end else if (op == OP_RETURN_HANDLER) begin
                        nxt_class  = CLS_INTR;
                        nxt_active = 1'b0;
                    end else begin
                        nxt_reply.status = STATUS_BAD_CMD;
                    end
                end else if (frame_done && !frame_sum_ok
                             && frame.addr == module_addr) begin
                    nxt_reply.valid  = 1'b1;
                    nxt_reply.opcode = op;
                    nxt_reply.status = STATUS_BAD_SUM;
                end
            end
            ST_VMODE: begin
                nxt_axis.valid    = 1'b1;
                nxt_axis.vel_mode = 1'b1;
                nxt_st            = ST_PARAM;
            end
            ST_PARAM: begin
                nxt_axis.valid = 1'b1;
                nxt_axis.param = pend_param_ff;
                nxt_axis.value = pend_value_ff;
                nxt_st         = ST_IDLE;
            end
            default: begin
                nxt_st = ST_IDLE;
            end
        endcase
        // Handler entry: no nesting while one runs.
        if (glob_ff && !active_ff && irq_request
            && src_en_ff[irq_number] && vec_ok_ff[irq_number]) begin
            nxt_enter  = 1'b1;
            nxt_active = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff         <= ST_IDLE;
            axis_ff       <= '0;
            reply_ff      <= '0;
            class_ff      <= CLS_NONE;
            pend_param_ff <= 8'h00;
            pend_value_ff <= 32'h0;
            glob_ff       <= 1'b0;
            enter_ff      <= 1'b0;
            active_ff     <= 1'b0;
            src_en_ff     <= '0;
            vec_ok_ff     <= '0;
            cfg_type_ff   <= 8'h00;
            cfg_val_ff    <= 32'h0;
        end else begin
            st_ff         <= nxt_st;
            axis_ff       <= nxt_axis;
            reply_ff      <= nxt_reply;
            class_ff      <= nxt_class;
            pend_param_ff <= nxt_pend_param;
            pend_value_ff <= nxt_pend_value;
            glob_ff       <= nxt_glob;
            enter_ff      <= nxt_enter;
            active_ff     <= nxt_active;
            src_en_ff     <= nxt_src_en;
            vec_ok_ff     <= nxt_vec_ok;
            cfg_type_ff   <= nxt_cfg_type;
            cfg_val_ff    <= nxt_cfg_val;
        end
    end

    assign axis_wr       = axis_ff;
    assign reply         = reply_ff;
    assign cmd_class     = class_ff;
    assign irq_global    = glob_ff;
    assign irq_enter     = enter_ff;
    assign irq_active    = active_ff;
    assign irq_cfg_type  = cfg_type_ff;
    assign irq_cfg_value = cfg_val_ff;

    // A rotate right frame writes velocity mode, then the parameter.
    a_motion_sequence: assert property (
        @(posedge clk) disable iff (!rst_b)
        (accept && op == OP_ROTATE_RIGHT) |=> ##1
        (axis_wr.valid && axis_wr.vel_mode) ##1
        (axis_wr.valid && axis_wr.param == AXIS_TARGET_VEL))
        else $error("rotate right sequence wrong");

    a_left_negates: assert property (
        @(posedge clk) disable iff (!rst_b)
        (accept && op == OP_ROTATE_LEFT) |=> ##2
        (axis_wr.value == 32'h0 - $past(frame.value, 3)))
        else $error("rotate left value not negated");

    a_stop_zero: assert property (
        @(posedge clk) disable iff (!rst_b)
        (accept && op == OP_SOFT_STOP) |=> ##2
        (axis_wr.param == AXIS_TARGET_SPEED && axis_wr.value == 32'h0))
        else $error("soft stop did not zero speed");

    a_reply_ok: assert property (
        @(posedge clk) disable iff (!rst_b)
        (accept && op == OP_ROTATE_LEFT) |=>
        (reply.valid && reply.status == STATUS_OK))
        else $error("motion reply not ok");

    a_bad_sum: assert property (
        @(posedge clk) disable iff (!rst_b)
        (frame_done && !frame_sum_ok) |=> !axis_wr.valid [*3])
        else $error("bad checksum frame acted on");

    a_foreign_addr: assert property (
        @(posedge clk) disable iff (!rst_b)
        (frame_done && frame.addr != module_addr) |=> !reply.valid)
        else $error("foreign frame answered");

    a_global_gate: assert property (
        @(posedge clk) disable iff (!rst_b)
        irq_enter |-> $past(irq_global))
        else $error("handler entered while globally disabled");

    a_no_nesting: assert property (
        @(posedge clk) disable iff (!rst_b)
        irq_enter |-> !$past(irq_active))
        else $error("nested handler entry");

    a_calc_class: assert property (
        @(posedge clk) disable iff (!rst_b)
        (accept && op >= OP_CALC_FIRST && op <= OP_CALC_LAST)
        |=> cmd_class == CLS_CALC)
        else $error("calc opcode misclassified");

endmodule

// ===== hdl/mcd_frame_rx.sv
`timescale 1ns/1ps
// Gathers nine bytes into one frame and checks the trailing checksum.
module mcd_frame_rx
    import mcd_pkg::*;
(
    input  wire logic          clk,          // System clock.
    input  wire logic          rst_b,        // Async reset, active low.
    input  wire logic          byte_valid,   // Incoming byte strobe.
    input  wire logic [7:0]    byte_data,    // Incoming byte.
    output mcd_frame_type      frame,        // Assembled frame.
    output logic               frame_done,   // Frame complete pulse.
    output logic               frame_sum_ok  // Checksum matched.
);
    logic [3:0]    cnt_ff, nxt_cnt;
    logic [7:0]    sum_ff, nxt_sum;
    mcd_frame_type frm_ff, nxt_frm;
    logic          done_ff, nxt_done;
    logic          ok_ff, nxt_ok;

    // Count bytes, shift fields in and keep a running sum.
    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_sum  = sum_ff;
        nxt_frm  = frm_ff;
        nxt_done = 1'b0;
        nxt_ok   = ok_ff;
        if (byte_valid) begin
            if (cnt_ff == 4'(FRAME_BYTES - 1)) begin
                nxt_cnt  = 4'h0;
                nxt_sum  = 8'h00;
                nxt_done = 1'b1;
                nxt_ok   = (byte_data == sum_ff);
            end else begin
                nxt_cnt = cnt_ff + 4'h1;
                nxt_sum = sum_ff + byte_data;
                nxt_frm = {frm_ff[55:0], byte_data};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff  <= 4'h0;
            sum_ff  <= 8'h00;
            frm_ff  <= '0;
            done_ff <= 1'b0;
            ok_ff   <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            sum_ff  <= nxt_sum;
            frm_ff  <= nxt_frm;
            done_ff <= nxt_done;
            ok_ff   <= nxt_ok;
        end
    end

    assign frame        = frm_ff;
    assign frame_done   = done_ff;
    assign frame_sum_ok = ok_ff;

endmodule

// ===== hdl/mcd_pkg.sv
package mcd_pkg;

    // Frame layout and field widths.
    localparam int unsigned FRAME_BYTES = 9;
    localparam logic [7:0] MODULE_ADDR_RST = 8'h01;

    // Opcodes of the motion, interrupt and extended commands.
    localparam logic [7:0] OP_ROTATE_RIGHT   = 8'h01;
    localparam logic [7:0] OP_ROTATE_LEFT    = 8'h02;
    localparam logic [7:0] OP_SOFT_STOP      = 8'h03;
    localparam logic [7:0] OP_SET_GLOBAL     = 8'h09;
    localparam logic [7:0] OP_INT_ENABLE     = 8'h19;
    localparam logic [7:0] OP_INT_DISABLE    = 8'h1a;
    localparam logic [7:0] OP_DEFINE_VECTOR  = 8'h25;
    localparam logic [7:0] OP_RETURN_HANDLER = 8'h26;
    localparam logic [7:0] OP_CALC_FIRST     = 8'h28;
    localparam logic [7:0] OP_CALC_LAST      = 8'h2d;
    localparam logic [7:0] OP_MOVE_ACCU_POS  = 8'h2e;
    localparam logic [7:0] OP_RESTART        = 8'h30;
    localparam logic [7:0] OP_DEC_BRANCH     = 8'h31;
    localparam logic [7:0] OP_ROTATE_L_ACCU  = 8'h32;
    localparam logic [7:0] OP_ROTATE_R_ACCU  = 8'h33;
    localparam logic [7:0] OP_SET_IDX_VAR    = 8'h37;
    localparam logic [7:0] OP_GET_IDX_VAR    = 8'h38;
    localparam logic [7:0] OP_ACCU_IDX_VAR   = 8'h39;
    localparam logic [7:0] OP_COND_CALL      = 8'h50;

    // Interrupt configuration values.
    localparam logic [7:0] INT_CFG_BANK      = 8'h03;
    localparam logic [7:0] INT_GLOBAL_NUM    = 8'hff;
    localparam logic [7:0] INT_TIMER_LAST    = 8'h02;

    // Axis parameters and reply status codes.
    localparam logic [7:0] AXIS_TARGET_SPEED = 8'h00;
    localparam logic [7:0] AXIS_TARGET_VEL   = 8'h02;
    localparam logic [7:0] STATUS_OK         = 8'h64;
    localparam logic [7:0] STATUS_BAD_SUM    = 8'h01;
    localparam logic [7:0] STATUS_BAD_CMD    = 8'h02;

    // Decoded command classes.
    typedef enum logic [3:0] {
        CLS_NONE    = 4'h0,
        CLS_MOTION  = 4'h1,
        CLS_CALC    = 4'h2,
        CLS_BRANCH  = 4'h3,
        CLS_INDEXED = 4'h4,
        CLS_INTR    = 4'h5,
        CLS_PARAM   = 4'h6
    } mcd_class_type;

    // One received frame.
    typedef struct packed {
        logic [7:0]  addr;
        logic [7:0]  opcode;
        logic [7:0]  ctype;
        logic [7:0]  bank;
        logic [31:0] value;
    } mcd_frame_type;

    // Write to the motion controller.
    typedef struct packed {
        logic        valid;
        logic        vel_mode;
        logic [7:0]  param;
        logic [31:0] value;
    } mcd_axis_wr_type;

    // Reply to the host.
    typedef struct packed {
        logic        valid;
        logic [7:0]  status;
        logic [7:0]  opcode;
    } mcd_reply_type;

endpackage

// ===== verif/mcd_host_model.sv
`timescale 1ns/1ps
// Host on the far side of the serial link; it sends nine-byte frames.
module mcd_host_model
    import mcd_pkg::*;
(
    input  wire logic clk,        // System clock.
    output logic      byte_valid, // Byte strobe towards the decoder.
    output logic [7:0] byte_data  // Byte on the link.
);
    // The link is quiet until the first frame.
    initial begin
        byte_valid = 1'b0;
        byte_data  = 8'h00;
    end

    // Sends one frame, a byte a cycle, changing at the falling edge.
    task automatic send(input logic [7:0] addr, input logic [7:0] op,
                        input logic [7:0] ctype, input logic [7:0] bank,
                        input logic [31:0] value, input logic bad_sum);
        logic [7:0] b [9];
        logic [7:0] sum;
        b = '{addr, op, ctype, bank, value[31:24], value[23:16],
              value[15:8], value[7:0], 8'h00};
        sum = 8'h00;
        for (int i = 0; i < 8; i++) begin
            sum = sum + b[i];
        end
        b[8] = bad_sum ? ~sum : sum;
        for (int i = 0; i < 9; i++) begin
            @(negedge clk);
            byte_valid = 1'b1;
            byte_data  = b[i];
        end
        @(negedge clk);
        byte_valid = 1'b0;
        byte_data  = ~b[8]; // A released line must not keep its value.
    endtask
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps
// Drives frames through the host model and scores replies and writes.
module testbench
    import mcd_pkg::*;
;
    logic            clk;
    logic            rst_b;
    logic            byte_valid;
    logic [7:0]      byte_data;
    logic [7:0]      module_addr;
    logic            irq_request;
    logic [7:0]      irq_number;
    mcd_axis_wr_type axis_wr;
    mcd_reply_type   reply;
    mcd_class_type   cmd_class;
    logic            irq_global;
    logic            irq_enter;
    logic            irq_active;
    logic [7:0]      irq_cfg_type;
    logic [31:0]     irq_cfg_value;
    int              fail_count = 0;
    int              compares = 0;
    int              n_enter = 0;
    int              v;
    logic            axis_on = 1'b1;
    logic [15:0]     rq[$];
    logic [40:0]     aq[$];
    logic [15:0]     er;
    logic [40:0]     ea;
    logic [7:0]      ops [15] = '{8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c,
        8'h2d, 8'h2e, 8'h30, 8'h31, 8'h50, 8'h32, 8'h33, 8'h37, 8'h38,
        8'h39};
    mcd_class_type   cls [15] = '{CLS_CALC, CLS_CALC, CLS_CALC, CLS_CALC,
        CLS_CALC, CLS_CALC, CLS_MOTION, CLS_BRANCH, CLS_BRANCH, CLS_BRANCH,
        CLS_MOTION, CLS_MOTION, CLS_INDEXED, CLS_INDEXED, CLS_INDEXED};

    mcd_host_model u_host (.clk(clk), .byte_valid(byte_valid),
                           .byte_data(byte_data));

    mcd_decoder u_dut (.clk(clk), .rst_b(rst_b), .byte_valid(byte_valid),
        .byte_data(byte_data), .module_addr(module_addr),
        .irq_request(irq_request), .irq_number(irq_number),
        .axis_wr(axis_wr), .reply(reply), .cmd_class(cmd_class),
        .irq_global(irq_global), .irq_enter(irq_enter),
        .irq_active(irq_active), .irq_cfg_type(irq_cfg_type),
        .irq_cfg_value(irq_cfg_value));

    // Clock of 40 ns period.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Compares one value and counts the result.
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Waits, bounded, until every noted result has appeared.
    task automatic settle();
        int n;
        n = 0;
        while ((rq.size() != 0 || aq.size() != 0) && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (rq.size() != 0 || aq.size() != 0) begin
            chk("timeout", 1, 0);
            test_done();
        end
        repeat (4) @(negedge clk);
    endtask

    // Sends a frame to this module and notes the reply it must bring.
    task automatic frame(input logic [7:0] op, input logic [7:0] ctype,
                         input logic [7:0] bank, input logic [31:0] val,
                         input logic [7:0] st);
        rq.push_back({st, op});
        u_host.send(MODULE_ADDR_RST, op, ctype, bank, val,
                    st == STATUS_BAD_SUM);
        settle();
    endtask

    // Motion frame: a velocity-mode write, then the parameter write.
    task automatic motion(input logic [7:0] op, input logic [31:0] val,
                          input logic [7:0] prm, input logic [31:0] ev);
        aq.push_back({1'b1, 8'h00, 32'h0});
        aq.push_back({1'b0, prm, ev});
        frame(op, 8'h00, 8'h00, val, STATUS_OK);
        chk("cmd_class", 32'(cmd_class), 32'(CLS_MOTION));
    endtask

    // Takes the oldest noted reply, and axis write while axis_on, whenever the decoder shows one.
    always @(posedge clk) begin
        if (irq_enter === 1'b1) begin
            n_enter++;
        end
        if (reply.valid === 1'b1) begin
            if (rq.size() == 0) begin
                chk("reply_extra", 1, 0);
            end else begin
                er = rq.pop_front();
                chk("reply_status", reply.status, er[15:8]);
                chk("reply_opcode", reply.opcode, er[7:0]);
            end
        end
        if (axis_wr.valid === 1'b1 && axis_on) begin
            if (aq.size() == 0) begin
                chk("axis_extra", 1, 0);
            end else begin
                ea = aq.pop_front();
                if (ea[40]) begin
                    chk("vel_mode", axis_wr.vel_mode, 1);
                end else begin
                    chk("axis_param", axis_wr.param, ea[39:32]);
                    chk("axis_value", axis_wr.value, ea[31:0]);
                end
            end
        end
    end

    // Main sequence.
    initial begin
        rst_b       = 1'b0;
        module_addr = MODULE_ADDR_RST;
        irq_request = 1'b0;
        irq_number  = 8'h00;
        v           = $urandom(32'h72e5);
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        chk("cmd_class", 32'(cmd_class), 32'(CLS_NONE));
        chk("irq_global", irq_global, 0);
        chk("irq_active", irq_active, 0);
        $display("test reset done");

        motion(OP_ROTATE_RIGHT, 32'h3e8, AXIS_TARGET_VEL, 32'h3e8);
        motion(OP_ROTATE_LEFT, 32'h3e8, AXIS_TARGET_VEL,
               -32'sd1000);
        for (int i = 0; i < 6; i++) begin
            v = int'($urandom_range(4094)) - 2047;
            if (i[0]) begin
                motion(OP_ROTATE_LEFT, 32'(v), AXIS_TARGET_VEL,
                       32'(-v));
            end else begin
                motion(OP_ROTATE_RIGHT, 32'(v), AXIS_TARGET_VEL,
                       32'(v));
            end
        end
        motion(OP_SOFT_STOP, 32'h0, AXIS_TARGET_SPEED, 32'h0);
        $display("test motion done");

        axis_on = 1'b0;
        for (int i = 0; i < 15; i++) begin
            frame(ops[i], 8'h00, 8'h00, 32'h0, STATUS_OK);
            if (cls[i] != CLS_NONE) begin
                chk("cmd_class", 32'(cmd_class),
                    32'(cls[i]));
            end
        end
        frame(8'hee, 8'h00, 8'h00, 32'h0, STATUS_BAD_CMD);
        axis_on = 1'b1;
        $display("test opcodes done");

        frame(OP_ROTATE_RIGHT, 8'h00, 8'h00, 32'h10,
              STATUS_BAD_SUM);
        u_host.send(8'h05, OP_ROTATE_LEFT, 8'h00, 8'h00, 32'h20, 1'b0);
        settle();
        $display("test refusals done");

        frame(OP_DEFINE_VECTOR, 8'h00, 8'h00, 32'h40, STATUS_OK);
        frame(OP_SET_GLOBAL, 8'h01, INT_CFG_BANK, 32'h3e8,
              STATUS_OK);
        frame(OP_SET_GLOBAL, 8'h02, 8'h00, 32'h7, STATUS_OK);
        chk("cfg_type", irq_cfg_type, 8'h01);
        chk("cfg_value", irq_cfg_value, 32'h3e8);
        frame(OP_INT_ENABLE, 8'h00, 8'h00, 32'h0, STATUS_OK);
        irq_request = 1'b1;
        repeat (4) @(negedge clk);
        irq_request = 1'b0;
        chk("enter_no_global", n_enter, 0);
        frame(OP_INT_ENABLE, INT_GLOBAL_NUM, 8'h00, 32'h0,
              STATUS_OK);
        chk("irq_global", irq_global, 1);
        for (int k = 0; k < 2; k++) begin
            irq_request = 1'b1;
            repeat (4) @(negedge clk);
            irq_request = 1'b0;
            repeat (2) @(negedge clk);
        end
        chk("enter_once", n_enter, 1);
        chk("irq_active", irq_active, 1);
        frame(OP_RETURN_HANDLER, 8'h00, 8'h00, 32'h0, STATUS_OK);
        chk("irq_active", irq_active, 0);
        frame(OP_INT_ENABLE, 8'h01, 8'h00, 32'h0, STATUS_OK);
        irq_number  = 8'h01;
        irq_request = 1'b1;
        repeat (4) @(negedge clk);
        irq_request = 1'b0;
        chk("enter_no_vector", n_enter, 1);
        frame(OP_INT_DISABLE, INT_GLOBAL_NUM, 8'h00, 32'h0, STATUS_OK);
        chk("irq_global", irq_global, 0);
        $display("test interrupts done");
        test_done();
    end
endmodule
